// ===== csfb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module csfb_bank
  import csfb_pkg::*;
#(
  parameter bit HAS_CACHE = 1'b1
) (
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_MODE_STRAP,
  input  wire logic                I_REG_WR,
  input  wire logic                I_REG_RD,
  input  wire logic [2:0]          I_REG_SEL,
  input  wire logic [15:0]         I_REG_WDATA,
  input  wire logic                I_BIT_SET,
  input  wire logic                I_BIT_CLR,
  input  wire logic [1:0]          I_BIT_WORD,
  input  wire logic [3:0]          I_BIT_POS,
  input  wire logic [3:0]          I_ACC_SEL,
  input  wire logic [39:0]         I_ACC_OVF_VEC,
  input  wire logic [3:0]          I_OV_TEST,
  input  wire csfb_pkg::csfb_carry_t I_CY_KIND,
  input  wire logic [39:0]         I_CY_VEC,
  input  wire logic                I_CY_SEL,
  input  wire logic                I_CY_VAL,
  input  wire logic                I_PAGE_WR,
  input  wire logic [15:0]         I_PAGE_WDATA,
  input  wire logic [15:0]         I_DIRECT_OFS,
  output logic [15:0]              O_REG_RDATA,
  output logic [15:0]              O_ST0,
  output logic [15:0]              O_ST1,
  output logic [15:0]              O_ST2,
  output logic [15:0]              O_ST3,
  output logic [15:0]              O_PAGE,
  output logic [22:0]              O_DIRECT_ADDR,
  output logic                     O_CARRY,
  output logic                     O_WIDE_MODE,
  output logic [3:0]               O_CACHE_CTRL
);
  import csfb_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic        prot;
  logic        wr0, wr1, wr2, wr3;
  logic [15:0] wmask;
  logic        bs0;
  logic        wide;
  logic        strap_q1, strap_q2;
  logic        rst_done;
  logic [15:0] st1, st2, st3;
  logic [15:0] page;
  logic        carry, tc1, tc2;
  logic [3:0]  ov;
  logic [3:0]  ov_ev;
  logic        cy_msb;
  logic [15:0] next_st0;

  assign prot = I_REG_SEL[2];
  assign wr0  = I_REG_WR && (I_REG_SEL == SEL_ST0 || I_REG_SEL == SEL_ST0_P);
  assign wr1  = I_REG_WR && (I_REG_SEL == SEL_ST1 || I_REG_SEL == SEL_ST1_P);
  assign wr2  = I_REG_WR && (I_REG_SEL == SEL_ST2);
  assign wr3  = I_REG_WR && (I_REG_SEL == SEL_ST3 || I_REG_SEL == SEL_ST3_P);
  assign bs0  = (I_BIT_SET || I_BIT_CLR) && I_BIT_WORD == 2'd0
                && I_BIT_POS >= 4'(MIRROR_W);
  assign wide = st1[BIT_WIDE];

  // Legacy code writes the alias; its mask keeps newer bits safe
  always_comb begin
    wmask = 16'hFFFF;
    if (prot) begin
      case (I_REG_SEL)
        SEL_ST0_P: wmask = ~PROT_ST0;
        SEL_ST1_P: wmask = ~PROT_ST1;
        SEL_ST3_P: wmask = ~PROT_ST3;
        default:   wmask = 16'hFFFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Overflow flags
  // ----------------------------------------------------------------
  csfb_if ovb ();

  assign cy_msb = wide ? I_CY_VEC[WIDE_MSB] : I_CY_VEC[NARROW_MSB];
  // Overflow vector holds a per-bit detect; pick the mode's bit
  assign ov_ev = I_ACC_SEL & {4{wide ? I_ACC_OVF_VEC[WIDE_MSB]
                                     : I_ACC_OVF_VEC[NARROW_MSB]}};

  function automatic logic [3:0] ov_bits(input logic [15:0] w);
    ov_bits = {w[BIT_OV3], w[BIT_OV2], w[BIT_OV1], w[BIT_OV0]};
  endfunction

  function automatic logic [3:0] ov_pos_hit(input logic [3:0] p);
    ov_pos_hit = {p == 4'(BIT_OV3), p == 4'(BIT_OV2),
                  p == 4'(BIT_OV1), p == 4'(BIT_OV0)};
  endfunction

  logic [3:0] bit_hit;
  logic [3:0] wmask_ov;
  assign bit_hit  = bs0 ? ov_pos_hit(I_BIT_POS) : 4'h0;
  assign wmask_ov = ov_bits(wmask) & {4{wr0}};

  assign ovb.set_ov = ov_ev | (bit_hit & {4{I_BIT_SET}});
  assign ovb.clr_ov = I_OV_TEST | (bit_hit & {4{I_BIT_CLR}});
  assign ovb.wr_ov  = wmask_ov;
  assign ovb.wr_val = ov_bits(I_REG_WDATA);
  assign ov         = ovb.ov;

  csfb_ovf #(
    .N (4)
  ) u_ovf (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .bus     (ovb)
  );

  // ----------------------------------------------------------------
  // Carry
  // ----------------------------------------------------------------
  logic bit_carry;
  assign bit_carry = bs0 && I_BIT_POS == 4'(BIT_CARRY);

  // Software write first, then bit ops, then datapath results
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      carry <= 1'b1;
    end else if (wr0 && wmask[BIT_CARRY]) begin
      carry <= I_REG_WDATA[BIT_CARRY];
    end else if (bit_carry && I_BIT_SET) begin
      carry <= 1'b1;
    end else if (bit_carry && I_BIT_CLR) begin
      carry <= 1'b0;
    end else begin
      case (I_CY_KIND)
        CY_ADD:   carry <= cy_msb;
        CY_ADD16: if (cy_msb) carry <= 1'b1;
        CY_SUB:   carry <= !cy_msb;
        CY_SUB16: if (cy_msb) carry <= 1'b0;
        CY_SHIFT: if (I_CY_SEL) carry <= I_CY_VAL;
        CY_MISC:  carry <= I_CY_VAL;
        default:  carry <= carry;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Test flags
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tc1 <= 1'b1;
    end else if (wr0 && wmask[BIT_TC1]) begin
      tc1 <= I_REG_WDATA[BIT_TC1];
    end else if (bs0 && I_BIT_POS == 4'(BIT_TC1)) begin
      tc1 <= I_BIT_SET;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tc2 <= 1'b1;
    end else if (wr0 && wmask[BIT_TC2]) begin
      tc2 <= I_REG_WDATA[BIT_TC2];
    end else if (bs0 && I_BIT_POS == 4'(BIT_TC2)) begin
      tc2 <= I_BIT_SET;
    end
  end

  // ----------------------------------------------------------------
  // Page register and mirror
  // ----------------------------------------------------------------
  // Register write wins over a datapath page load
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      page <= 16'h0000;
    end else if (wr0) begin
      page[15:PAGE_LSB] <= I_REG_WDATA[MIRROR_W-1:0];
    end else if (I_PAGE_WR) begin
      page <= I_PAGE_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Words one to three and strap
  // ----------------------------------------------------------------
  // No reset here: the pin must be settled when reset lifts
  always_ff @(posedge I_CLK) begin
    strap_q1 <= I_MODE_STRAP;
    strap_q2 <= strap_q1;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_done <= 1'b0;
    end else begin
      rst_done <= 1'b1;
    end
  end

  function automatic logic [15:0] bitop(input logic [15:0] w, input logic [1:0] idx);
    logic [15:0] r;
    r = w;
    if (I_BIT_WORD == idx && I_BIT_SET) r[I_BIT_POS] = 1'b1;
    if (I_BIT_WORD == idx && I_BIT_CLR) r[I_BIT_POS] = 1'b0;
    bitop = r;
  endfunction

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st1 <= RST_ST1;
    end else if (wr1) begin
      st1 <= (st1 & ~wmask) | (I_REG_WDATA & wmask);
    end else begin
      st1 <= bitop(st1, 2'd1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st2 <= RST_ST2;
    end else if (wr2) begin
      st2 <= (st2 & RO_ST2) | (I_REG_WDATA & ~RO_ST2);
    end else begin
      st2 <= (st2 & RO_ST2) | (bitop(st2, 2'd2) & ~RO_ST2);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st3 <= RST_ST3;
    end else if (!rst_done) begin
      st3[BIT_MICRO] <= strap_q2;
    end else if (wr3) begin
      st3 <= (st3 & (~wmask | RO_ST3)) | (I_REG_WDATA & wmask & ~RO_ST3);
    end else begin
      st3 <= (st3 & RO_ST3) | (bitop(st3, 2'd3) & ~RO_ST3);
    end
  end

  // ----------------------------------------------------------------
  // Readback and outputs
  // ----------------------------------------------------------------
  assign next_st0 = {ov[2], ov[3], tc1, tc2, carry, ov[0], ov[1],
                     page[15:PAGE_LSB]};

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= 16'h0000;
    end else if (I_REG_RD) begin
      case (I_REG_SEL)
        SEL_ST0:   O_REG_RDATA <= next_st0;
        SEL_ST1:   O_REG_RDATA <= st1;
        SEL_ST2:   O_REG_RDATA <= st2;
        SEL_ST3:   O_REG_RDATA <= st3;
        SEL_ST0_P: O_REG_RDATA <= next_st0 & ~PROT_ST0;
        SEL_ST1_P: O_REG_RDATA <= st1 & ~PROT_ST1;
        SEL_ST3_P: O_REG_RDATA <= st3 & ~PROT_ST3;
        default:   O_REG_RDATA <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ST0         <= RST_ST0;
      O_ST1         <= RST_ST1;
      O_ST2         <= RST_ST2;
      O_ST3         <= RST_ST3;
      O_PAGE        <= 16'h0000;
    end else begin
      O_ST0         <= next_st0;
      O_ST1         <= st1;
      O_ST2         <= st2;
      O_ST3         <= st3;
      O_PAGE        <= page;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DIRECT_ADDR <= 23'h00_0000;
      O_CARRY       <= 1'b1;
      O_WIDE_MODE   <= 1'b0;
      O_CACHE_CTRL  <= 4'h0;
    end else begin
      // Full sixteen page bits, never the mirror alone
      O_DIRECT_ADDR <= 23'(page) + 23'(I_DIRECT_OFS);
      O_CARRY       <= carry;
      O_WIDE_MODE   <= wide;
      // No cache fitted: controls held inert
      O_CACHE_CTRL  <= HAS_CACHE ? st3[15:12] & 4'hE : 4'h0;
    end
  end
endmodule // csfb_bank
`default_nettype wire

// ===== csfb_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module csfb_bank_chk
  import csfb_pkg::*;
(
  input wire logic                   I_CLK,
  input wire logic                   I_RST_N,
  input wire logic                   I_REG_WR,
  input wire logic                   I_REG_RD,
  input wire logic [2:0]             I_REG_SEL,
  input wire logic                   I_BIT_SET,
  input wire logic                   I_BIT_CLR,
  input wire logic [3:0]             I_ACC_SEL,
  input wire logic [39:0]            I_ACC_OVF_VEC,
  input wire logic [3:0]             I_OV_TEST,
  input wire csfb_pkg::csfb_carry_t  I_CY_KIND,
  input wire logic [39:0]            I_CY_VEC,
  input wire logic                   I_PAGE_WR,
  input wire logic [15:0]            I_PAGE_WDATA,
  input wire logic [15:0]            O_REG_RDATA,
  input wire logic [15:0]            O_ST0,
  input wire logic                   O_CARRY,
  input wire logic                   O_WIDE_MODE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // ----------------------------------------
  // Mode output lags state, so skip a cycle after writes
  // ----------------------------------------
  logic      busy_d;
  wire logic quiet = !(I_REG_WR || I_BIT_SET || I_BIT_CLR);
  wire logic narrow = quiet && !busy_d && !O_WIDE_MODE;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      busy_d <= 1'b0;
    end else begin
      busy_d <= !quiet;
    end
  end
  a_ovf_narrow: assert property (narrow && I_ACC_SEL[0] && I_ACC_OVF_VEC[31] |-> ##2 O_ST0[10])
    else $error("overflow flag 0 not set");
  a_ovf_sticky: assert property (O_ST0[10] && !busy_d && !$past(I_OV_TEST[0]) |=> O_ST0[10])
    else $error("overflow flag 0 lost");
  a_test_clear: assert property (quiet && I_OV_TEST[1] && !I_ACC_SEL[1] |-> ##2 !O_ST0[9])
    else $error("overflow flag 1 not cleared");
  a_add_carry: assert property (narrow && I_CY_KIND == CY_ADD |-> ##2 O_CARRY == $past(I_CY_VEC[31], 2))
    else $error("add carry wrong");
  a_sub_borrow: assert property (narrow && I_CY_KIND == CY_SUB |-> ##2 O_CARRY != $past(I_CY_VEC[31], 2))
    else $error("sub carry wrong");
  a_add16_hold: assert property (narrow && I_CY_KIND == CY_ADD16 && !I_CY_VEC[31] |-> ##2 $stable(O_CARRY))
    else $error("shifted add changed carry");
  a_page_mirror: assert property (I_PAGE_WR && !I_REG_WR |-> ##2 O_ST0[8:0] == $past(I_PAGE_WDATA[15:7], 2))
    else $error("page mirror wrong");
  a_prot_read: assert property (I_REG_RD && I_REG_SEL == SEL_ST0_P |=> (O_REG_RDATA & PROT_ST0) == 16'h0000)
    else $error("protected bits visible");
  c_test: cover property (I_OV_TEST != 4'h0);
  c_prot: cover property (I_REG_WR && I_REG_SEL == SEL_ST0_P);
  c_wide: cover property (O_WIDE_MODE && I_CY_KIND == CY_ADD);
endmodule // csfb_bank_chk
bind csfb_bank csfb_bank_chk u_chk (.I_CLK, .I_RST_N, .I_REG_WR, .I_REG_RD, .I_REG_SEL, .I_BIT_SET, .I_BIT_CLR,
  .I_ACC_SEL, .I_ACC_OVF_VEC, .I_OV_TEST, .I_CY_KIND, .I_CY_VEC, .I_PAGE_WR, .I_PAGE_WDATA, .O_REG_RDATA,
  .O_ST0, .O_CARRY, .O_WIDE_MODE);
`default_nettype wire

// ===== csfb_dp.sv
`timescale 1ns/1ps
`default_nettype none
module csfb_dp
  import csfb_pkg::*;
(
  output logic [3:0]             o_acc_sel,
  output logic [39:0]            o_ovf_vec,
  output logic [3:0]             o_ov_test,
  output csfb_pkg::csfb_carry_t  o_cy_kind,
  output logic [39:0]            o_cy_vec,
  output logic                   o_cy_sel,
  output logic                   o_cy_val
);
  // Caller steps the clock; one call's results hold until the next call
  task automatic go(input csfb_carry_t k, input logic [39:0] cv, input logic [3:0] acc,
                    input logic [39:0] ov, input logic [3:0] tst, input logic s, input logic v);
    o_cy_kind = k;
    o_cy_vec = cv;
    o_acc_sel = acc;
    o_ovf_vec = ov;
    o_ov_test = tst;
    o_cy_sel = s;
    o_cy_val = v;
  endtask
  initial go(CY_NONE, '0, '0, '0, '0, 1'b0, 1'b0);
endmodule // csfb_dp
`default_nettype wire

// ===== csfb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface csfb_if;
  logic [3:0] set_ov;
  logic [3:0] clr_ov;
  logic [3:0] wr_ov;
  logic [3:0] wr_val;
  logic [3:0] ov;
  modport owner (input set_ov, clr_ov, wr_ov, wr_val, output ov);
  modport user  (output set_ov, clr_ov, wr_ov, wr_val, input ov);
endinterface
`default_nettype wire

// ===== csfb_ovf.sv
`timescale 1ns/1ps
`default_nettype none
module csfb_ovf #(
  parameter int N = 4
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  csfb_if.owner       bus
);
  // Carrier holds four flags, so more cannot be served
  if (N < 1 || N > 4) begin : g_bad_n
    $error("csfb_ovf: N must lie between 1 and 4");
  end

  // One process owns the whole flag vector
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus.ov <= 4'h0;
    end else begin
      for (int k = 0; k < N; k++) begin
        if (bus.wr_ov[k]) begin
          bus.ov[k] <= bus.wr_val[k];
        end else if (bus.set_ov[k]) begin
          bus.ov[k] <= 1'b1;
        end else if (bus.clr_ov[k]) begin
          bus.ov[k] <= 1'b0;
        end
      end
    end
  end
endmodule // csfb_ovf
`default_nettype wire

// ===== csfb_pkg.sv
// Contract
// - Four overflow flags at bits 10,9,15,14
// - Overflow detected at bit 31 or 39
// - Overflow event sets that accumulator's flag
// - Flag sticky until reset, test or clear
// - Carry taken at bit 31 or 39
// - Add sets carry on carry, clears otherwise
// - Shifted add only sets carry on carry
// - Subtract clears carry on borrow, else sets
// - Shifted subtract only clears carry on borrow
// - Logical shifts update carry; others optional
// - Min/max/abs/neg to accumulator update carry
// - Single-bit set/clear for carry, overflows
// - Page mirror tracks page bits both ways
// - Direct addressing uses full page register
// - Protected alias masks and hides compat bits
// - Reset loads documented field values
// - Mode bit reset value from strap pins
// - Cache bits inert without a cache
// - Words zero, one, three have two aliases
package csfb_pkg;
  // ----------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_ST0   = 3'h0;
  localparam logic [2:0] SEL_ST1   = 3'h1;
  localparam logic [2:0] SEL_ST2   = 3'h2;
  localparam logic [2:0] SEL_ST3   = 3'h3;
  localparam logic [2:0] SEL_ST0_P = 3'h4;
  localparam logic [2:0] SEL_ST1_P = 3'h5;
  localparam logic [2:0] SEL_ST3_P = 3'h7;
  // ----------------------------------------------------------------
  // Field positions of words zero, one and three, and detect bits
  // ----------------------------------------------------------------
  localparam int BIT_OV2   = 15;
  localparam int BIT_OV3   = 14;
  localparam int BIT_TC1   = 13;
  localparam int BIT_TC2   = 12;
  localparam int BIT_CARRY = 11;
  localparam int BIT_OV0   = 10;
  localparam int BIT_OV1   = 9;
  localparam int BIT_WIDE  = 10;
  localparam int BIT_MICRO = 6;
  localparam int PAGE_LSB  = 7;
  localparam int MIRROR_W  = 9;
  localparam int NARROW_MSB = 31;
  localparam int WIDE_MSB  = 39;
  // ----------------------------------------------------------------
  // Reset values and protected masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ST0  = 16'h3800;
  localparam logic [15:0] RST_ST1  = 16'h2920;
  localparam logic [15:0] RST_ST2  = 16'h7000;
  localparam logic [15:0] RST_ST3  = 16'h1C00;
  localparam logic [15:0] PROT_ST0 = 16'hE400;
  localparam logic [15:0] PROT_ST1 = 16'h0420;
  localparam logic [15:0] PROT_ST3 = 16'hF0A0;
  localparam logic [15:0] RO_ST2   = 16'h6200;
  localparam logic [15:0] RO_ST3   = 16'h0008;
  localparam logic [15:0] CACHE_ST3 = 16'hE000;
  // ----------------------------------------------------------------
  // Carry event kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CY_NONE, CY_ADD, CY_ADD16, CY_SUB, CY_SUB16, CY_SHIFT, CY_MISC
  } csfb_carry_t;
endpackage

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
  import csfb_pkg::*;
  logic        I_CLK, I_RST_N, I_MODE_STRAP, I_REG_WR, I_REG_RD, I_BIT_SET, I_BIT_CLR;
  logic        I_CY_SEL, I_CY_VAL, I_PAGE_WR, O_CARRY, O_WIDE_MODE;
  logic [1:0]  I_BIT_WORD;
  logic [2:0]  I_REG_SEL;
  logic [3:0]  I_BIT_POS, I_ACC_SEL, I_OV_TEST, O_CACHE_CTRL;
  logic [15:0] I_REG_WDATA, I_PAGE_WDATA, I_DIRECT_OFS, O_REG_RDATA, O_ST0, O_ST1, O_ST2, O_ST3, O_PAGE;
  logic [22:0] O_DIRECT_ADDR;
  logic [39:0] I_ACC_OVF_VEC, I_CY_VEC;
  csfb_carry_t I_CY_KIND;
  int          num_errors = 0;
  int          check_count = 0;
  // No cache variant, so cache bits must stay inert
  csfb_bank #(.HAS_CACHE(1'b0)) dut (.I_CLK, .I_RST_N, .I_MODE_STRAP, .I_REG_WR, .I_REG_RD, .I_REG_SEL,
    .I_REG_WDATA, .I_BIT_SET, .I_BIT_CLR, .I_BIT_WORD, .I_BIT_POS, .I_ACC_SEL, .I_ACC_OVF_VEC, .I_OV_TEST,
    .I_CY_KIND, .I_CY_VEC, .I_CY_SEL, .I_CY_VAL, .I_PAGE_WR, .I_PAGE_WDATA, .I_DIRECT_OFS, .O_REG_RDATA,
    .O_ST0, .O_ST1, .O_ST2, .O_ST3, .O_PAGE, .O_DIRECT_ADDR, .O_CARRY, .O_WIDE_MODE, .O_CACHE_CTRL);
  csfb_dp dp (.o_acc_sel(I_ACC_SEL), .o_ovf_vec(I_ACC_OVF_VEC), .o_ov_test(I_OV_TEST), .o_cy_kind(I_CY_KIND),
    .o_cy_vec(I_CY_VEC), .o_cy_sel(I_CY_SEL), .o_cy_val(I_CY_VAL));
  initial begin
    I_CLK = 1'b0;
    forever #50 I_CLK = ~I_CLK;
  end
  // ----------------------------------------
  // Drivers: every change lands 1 ns after a rising edge
  // ----------------------------------------
  task tick;
    @(posedge I_CLK);
    #1;
  endtask
  task idle(input int n);
    repeat (n) begin
      tick;
      {I_REG_WR, I_REG_RD, I_BIT_SET, I_BIT_CLR, I_PAGE_WR} = '0;
      dp.go(CY_NONE, '0, '0, '0, '0, 1'b0, 1'b0);
    end
  endtask
  task wr(input logic [2:0] s, input logic [15:0] d);
    tick;
    I_REG_WR = 1'b1;
    I_REG_SEL = s;
    I_REG_WDATA = d;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    `CHK("st0", RST_ST0, O_ST0)
    `CHK("st1", RST_ST1, O_ST1)
    `CHK("st2", RST_ST2, O_ST2)
    `CHK("st3", RST_ST3 | 16'h0040, O_ST3)
  endtask
  task automatic t_ovf;
    int pos[4] = '{BIT_OV0, BIT_OV1, BIT_OV2, BIT_OV3};
    for (int k = 0; k < 4; k++) begin
      tick;
      dp.go(CY_NONE, '0, 4'(1 << k), 40'h80_0000_0000, 4'h0, 1'b0, 1'b0);
      idle(2);
      `CHK("ovf39", 1'b0, O_ST0[pos[k]])
      tick;
      dp.go(CY_NONE, '0, 4'(1 << k), 40'h00_8000_0000, 4'h0, 1'b0, 1'b0);
      idle(4);
      `CHK("ovf map", 16'(1 << pos[k]), O_ST0 & 16'hC600)
      tick;
      dp.go(CY_NONE, '0, 4'h0, '0, 4'(1 << k), 1'b0, 1'b0);
      idle(2);
      `CHK("ovf test", 1'b0, O_ST0[pos[k]])
    end
  endtask
  task automatic t_bits;
    int p[2] = '{BIT_OV2, BIT_CARRY};
    for (int i = 0; i < 4; i++) begin
      tick;
      I_BIT_SET = ~i[0];
      I_BIT_CLR = i[0];
      I_BIT_WORD = 2'h0;
      I_BIT_POS = 4'(p[i / 2]);
      idle(2);
      `CHK("bit op", ~i[0], O_ST0[p[i / 2]])
    end
  endtask
  task automatic t_carry;
    csfb_carry_t k[11] = '{CY_ADD, CY_ADD, CY_ADD16, CY_ADD16, CY_SUB, CY_SUB16, CY_SUB, CY_SUB16,
                           CY_SHIFT, CY_SHIFT, CY_MISC};
    logic [10:0] v = 11'h095;
    logic [10:0] sv = 11'h100;
    logic [10:0] e = 11'h34D;
    for (int i = 0; i < 11; i++) begin
      tick;
      dp.go(k[i], {8'h00, v[i], 31'h0000_0000}, 4'h0, '0, 4'h0, sv[i], sv[i]);
      idle(2);
      `CHK("carry", e[i], O_CARRY)
    end
  endtask
  task t_wide;
    wr(SEL_ST1, RST_ST1 | 16'h0400);
    idle(2);
    `CHK("wide", 1'b1, O_WIDE_MODE)
    tick;
    dp.go(CY_ADD, 40'h00_8000_0000, 4'h8, 40'h00_8000_0000, 4'h0, 1'b0, 1'b0);
    idle(2);
    `CHK("cy31", 1'b0, O_CARRY)
    `CHK("ov31", 1'b0, O_ST0[BIT_OV3])
    tick;
    dp.go(CY_ADD, 40'h80_0000_0000, 4'h8, 40'h80_0000_0000, 4'h0, 1'b0, 1'b0);
    idle(2);
    `CHK("cy39", 1'b1, O_CARRY)
    `CHK("ov39", 1'b1, O_ST0[BIT_OV3])
    wr(SEL_ST1, RST_ST1);
    idle(1);
    wr(SEL_ST0, 16'h0000);
    dp.go(CY_ADD, 40'h00_8000_0000, 4'h0, '0, 4'h0, 1'b0, 1'b0);
    idle(2);
    `CHK("wr wins", 1'b0, O_CARRY)
  endtask
  task t_page;
    tick;
    I_PAGE_WR = 1'b1;
    I_PAGE_WDATA = 16'hABCD;
    I_DIRECT_OFS = 16'h1234;
    idle(2);
    `CHK("mirror", 9'h157, O_ST0[8:0])
    `CHK("daddr", 23'h00_BE01, O_DIRECT_ADDR)
    wr(SEL_ST0, {O_ST0[15:9], 9'h0AA});
    idle(2);
    `CHK("page", 16'h554D, O_PAGE)
    `CHK("daddr2", 23'h00_6781, O_DIRECT_ADDR)
    wr(SEL_ST0, O_ST0 | 16'h3800);
    idle(2);
    `CHK("rmw page", 16'h554D, O_PAGE)
    `CHK("rmw tc", 3'h7, O_ST0[13:11])
  endtask
  task automatic t_prot;
    logic [2:0]  s[3] = '{SEL_ST0_P, SEL_ST0, 3'h6};
    logic [15:0] e[3] = '{16'h0000, 16'hE400, 16'h0000};
    wr(SEL_ST0, 16'hFE00);
    idle(1);
    wr(SEL_ST0_P, 16'h0000);
    idle(2);
    `CHK("prot wr", PROT_ST0, O_ST0)
    for (int i = 0; i < 3; i++) begin
      tick;
      I_REG_RD = 1'b1;
      I_REG_SEL = s[i];
      idle(2);
      `CHK("rdata", e[i], O_REG_RDATA)
    end
    wr(SEL_ST3, 16'hEC00);
    idle(2);
    `CHK("cache", 4'h0, O_CACHE_CTRL)
  endtask
  task rd(input logic [2:0] s);
    tick;
    I_REG_RD = 1'b1;
    I_REG_SEL = s;
    idle(2);
  endtask
  task t_alias;
    wr(SEL_ST1_P, 16'hFFFF);
    idle(2);
    `CHK("st1 prot", 16'hFBFF, O_ST1)
    `CHK("wide held", 1'b0, O_WIDE_MODE)
    wr(SEL_ST2, 16'hFFFF);
    idle(2);
    `CHK("st2 ro", 16'hFDFF, O_ST2)
    rd(SEL_ST2);
    `CHK("st2 rd", 16'hFDFF, O_REG_RDATA)
    wr(SEL_ST3_P, 16'h0C00);
    idle(2);
    `CHK("st3 prot", 16'hEC00, O_ST3)
    rd(SEL_ST3_P);
    `CHK("st3 rd", 16'h0C00, O_REG_RDATA)
    rd(SEL_ST1_P);
    `CHK("st1 rd", 16'hFBDF, O_REG_RDATA)
  endtask
  initial begin
    {I_RST_N, I_REG_WR, I_REG_RD, I_BIT_SET, I_BIT_CLR, I_PAGE_WR, I_REG_SEL} = '0;
    {I_REG_WDATA, I_BIT_WORD, I_BIT_POS, I_PAGE_WDATA, I_DIRECT_OFS} = '0;
    I_MODE_STRAP = 1'b1;
    repeat (6) @(posedge I_CLK);
    #1;
    I_RST_N = 1'b1;
    idle(3);
    t_reset;
    t_ovf;
    t_bits;
    t_carry;
    t_wide;
    t_page;
    t_prot;
    t_alias;
    wrap_up;
  end
  // Whole run is near 160 cycles; a hang is cut well past that
  initial begin
    repeat (3000) @(posedge I_CLK);
    num_errors++;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
